//--- design/bflc_top.sv
// Burst-mode, PWM latch and latched fault sequencer of a half-bridge controller
`timescale 1ns/1ps
module bflc_top
  import bflc_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  input  wire logic osc_clock_pulse_in,
  input  wire logic comp_below_stop_in,
  input  wire logic comp_above_restart_in,
  input  wire logic sense_at_setpoint_in,
  input  wire logic sense_over_ocp_in,
  input  wire logic latched_disable_input,
  input  wire logic vcc_above_startup_in,
  input  wire logic vcc_below_undervoltage_lockout_in,
  input  wire logic vcc_below_restart_in,
  input  wire logic vcc_below_startup_less_1v_in,
  input  wire logic line_ok_in,
  output logic      high_gate_out,
  output logic      low_gate_out,
  output logic      osc_enable_out,
  output logic      low_power_out,
  output logic      preregulator_stop_output,
  output logic      preregulator_stop_oe_out,
  output logic      hv_start_enable,
  output logic      supply_good_out,
  output logic      ocp_warning_out,
  output logic      ocp_latched_out,
  output logic      disable_latched_out,
  output logic      burst_idle_out
);
  bflc_flags_if flags ();

  logic [FLAG_COUNT-1:0] raw;
  always_comb begin
    raw               = '0;
    raw[F_BURST_LOW]  = comp_below_stop_in;
    raw[F_BURST_HIGH] = comp_above_restart_in;
    raw[F_PWM_TRIP]   = sense_at_setpoint_in;
    raw[F_OCP_TRIP]   = sense_over_ocp_in;
    raw[F_DISABLE]    = latched_disable_input;
    raw[F_VCC_ON]     = vcc_above_startup_in;
    raw[F_VCC_UNDERVOLTAGE_LOCKOUT]   = vcc_below_undervoltage_lockout_in;
    raw[F_VCC_REST]   = vcc_below_restart_in;
    raw[F_VCC_DROP]   = vcc_below_startup_less_1v_in;
  end

  bflc_sync #(
    .WIDTH    (FLAG_COUNT)
  ) u_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .ce_in    (ce_in),
    .raw_in   (raw),
    .sync_out (flags.src)
  );

  logic burst_low;
  logic burst_high;
  logic pwm_trip;
  logic ocp_trip;
  logic dis_trip;
  logic vcc_on;
  logic vcc_undervoltage_lockout;
  logic vcc_rest;
  logic vcc_drop;
  assign burst_low  = flags.flag[F_BURST_LOW];
  assign burst_high = flags.flag[F_BURST_HIGH];
  assign pwm_trip   = flags.flag[F_PWM_TRIP];
  assign ocp_trip   = flags.flag[F_OCP_TRIP];
  assign dis_trip   = flags.flag[F_DISABLE];
  assign vcc_on     = flags.flag[F_VCC_ON];
  assign vcc_undervoltage_lockout   = flags.flag[F_VCC_UNDERVOLTAGE_LOCKOUT];
  assign vcc_rest   = flags.flag[F_VCC_REST];
  assign vcc_drop   = flags.flag[F_VCC_DROP];

  // Oscillator pulse edge, same clock domain so no synchroniser
  logic osc_q;
  logic osc_edge;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_q <= 1'b0;
    end else if (ce_in) begin
      osc_q <= osc_clock_pulse_in;
    end
  end
  assign osc_edge = osc_clock_pulse_in && !osc_q;

  // Odd/even pulse split; even starts a switching cycle
  logic phase_q;
  logic even_pulse;
  logic odd_pulse;
  assign even_pulse = osc_edge && phase_q;
  assign odd_pulse  = osc_edge && !phase_q;

  bflc_state_e state_q;
  logic [3:0]  boot_cnt_q;
  logic        ocp_shut;
  logic        ocp_warn;
  logic        switching;
  assign switching = (state_q == BFLC_RUN);

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q <= 1'b0;
    end else if (ce_in) begin
      if (state_q != BFLC_RUN && state_q != BFLC_BOOT) begin
        phase_q <= 1'b0;
      end else if (osc_edge) begin
        phase_q <= !phase_q;
      end
    end
  end

  bflc_ocp u_ocp (
    .mclk_in        (mclk_in),
    .reset_in       (reset_in),
    .ce_in          (ce_in),
    .active_in      (switching),
    .cycle_start_in (even_pulse),
    .ocp_trip_in    (ocp_trip),
    .undervoltage_lockout_in        (vcc_undervoltage_lockout),
    .warn_out       (ocp_warn),
    .shut_out       (ocp_shut)
  );

  // Main sequencer
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= BFLC_OFF;
    end else if (ce_in) begin
      case (state_q)
        BFLC_OFF: begin
          if (vcc_on && !vcc_undervoltage_lockout && line_ok_in) begin
            state_q <= BFLC_BOOT;
          end
        end
        BFLC_BOOT, BFLC_RUN, BFLC_BURST: begin
          if (vcc_undervoltage_lockout) begin
            state_q <= BFLC_OFF;
          end else if (dis_trip) begin
            state_q <= BFLC_DIS;
          end else if (ocp_shut) begin
            state_q <= BFLC_OCP;
          end else if (!line_ok_in) begin
            state_q <= BFLC_OFF;
          end else if (state_q != BFLC_BURST && burst_low) begin
            state_q <= BFLC_BURST;
          end else if (state_q == BFLC_BURST && burst_high) begin
            state_q <= BFLC_BOOT;
          end else if (state_q == BFLC_BOOT && boot_cnt_q == BOOT_CYCLES) begin
            state_q <= BFLC_RUN;
          end
        end
        BFLC_OCP: begin
          if (vcc_undervoltage_lockout) begin
            state_q <= BFLC_OFF;
          end
        end
        BFLC_DIS: begin
          if (vcc_undervoltage_lockout) begin
            state_q <= BFLC_OFF;
          end
        end
        default: state_q <= BFLC_OFF;
      endcase
    end
  end

  // Bootstrap precharge: low side on for a count of oscillator pulses
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      boot_cnt_q <= '0;
    end else if (ce_in) begin
      if (state_q != BFLC_BOOT) begin
        boot_cnt_q <= '0;
      end else if (osc_edge && boot_cnt_q != BOOT_CYCLES) begin
        boot_cnt_q <= boot_cnt_q + 4'h1;
      end
    end
  end

  // PWM latch and gate drive
  logic pwm_off_q;
  logic high_q;
  logic low_q;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pwm_off_q <= 1'b1;
    end else if (ce_in) begin
      if (!switching) begin
        pwm_off_q <= 1'b1;
      end else if (even_pulse) begin
        pwm_off_q <= 1'b0;
      end else if (pwm_trip || ocp_trip || odd_pulse) begin
        pwm_off_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      high_q <= 1'b0;
      low_q  <= 1'b0;
    end else if (ce_in) begin
      if (state_q == BFLC_BOOT) begin
        high_q <= 1'b0;
        low_q  <= 1'b1;
      end else if (!switching) begin
        high_q <= 1'b0;
        low_q  <= 1'b0;
      end else if (pwm_trip || pwm_off_q || odd_pulse) begin
        high_q <= 1'b0;
        low_q  <= !osc_edge;
      end else begin
        high_q <= !osc_edge;
        low_q  <= 1'b0;
      end
    end
  end
  // Dead time is one clock at each oscillator pulse edge, whatever the pulse width; both gates drop on a pulse

  // Supply-good and start-up generator control
  logic supply_good_q;
  logic hv_q;
  logic hiccup_q;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      supply_good_q <= 1'b0;
    end else if (ce_in) begin
      if (vcc_rest) begin
        supply_good_q <= 1'b0;
      end else if (vcc_on) begin
        supply_good_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hiccup_q <= 1'b0;
    end else if (ce_in) begin
      if (state_q == BFLC_OCP) begin
        hiccup_q <= 1'b1;
      end else if (vcc_rest) begin
        hiccup_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      hv_q <= 1'b1;
    end else if (ce_in) begin
      if (state_q == BFLC_DIS) begin
        if (vcc_on) begin
          hv_q <= 1'b0;
        end else if (vcc_drop) begin
          hv_q <= 1'b1;
        end
      end else if (hiccup_q || state_q == BFLC_OCP) begin
        hv_q <= 1'b0;
      end else begin
        hv_q <= !supply_good_q;
      end
    end
  end

  // pull low only in burst idle
  logic pstop_q;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pstop_q <= 1'b0;
    end else if (ce_in) begin
      pstop_q <= (state_q == BFLC_BURST) && !vcc_undervoltage_lockout;
    end
  end

  assign high_gate_out            = high_q;
  assign low_gate_out             = low_q;
  assign osc_enable_out           = (state_q == BFLC_RUN) || (state_q == BFLC_BOOT);
  assign low_power_out            = !osc_enable_out;
  assign preregulator_stop_output = 1'b0;
  assign preregulator_stop_oe_out = pstop_q;
  assign hv_start_enable          = hv_q;
  assign supply_good_out          = supply_good_q;
  assign ocp_warning_out          = ocp_warn;
  assign ocp_latched_out          = (state_q == BFLC_OCP);
  assign disable_latched_out      = (state_q == BFLC_DIS);
  assign burst_idle_out           = (state_q == BFLC_BURST);
endmodule : bflc_top

//--- inc/bflc_pkg.sv
// Constants and types shared by the burst and fault latch sequencer
// What this block does
// - Control voltage under the burst stop level turns both gates off, stops the oscillator and idles.
// - From burst idle, switching resumes once the control voltage is above the restart level.
// - The pre-regulator stop output is open-collector, released except while idle in burst mode.
// - During undervoltage lockout the pre-regulator stop output stays released.
// - The high-side gate turns off when the sense voltage reaches the control-derived level.
// - A PWM latch holds the turn-off decision for the rest of the cycle.
// - A second comparator flags sense voltage above the overcurrent level for the fault logic.
// - First trip gives a warning, a clean next cycle clears it, a second consecutive trip shuts down.
// - The overcurrent shutdown stays latched until the supply drops below lockout.
// - After an overcurrent latch clears, start-up stays off until supply falls below restart level.
// - Disable input above its threshold shuts the device down at once with low consumption.
// - The disable shutdown is latched and clears only when supply drops below lockout.
// - While disable is latched, start-up cycles on and off to hold supply near the start threshold.
// - Activity stops below the lockout threshold and begins when supply reaches the start threshold.
// - Supply-good drops below the restart threshold, re-enabling start-up whatever the line input state.
package bflc_pkg;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned FLAG_COUNT  = 9;
  localparam logic [3:0]  BOOT_CYCLES = 4'ha;
  // Flag positions in the comparator vector
  localparam int unsigned F_BURST_LOW  = 0;
  localparam int unsigned F_BURST_HIGH = 1;
  localparam int unsigned F_PWM_TRIP   = 2;
  localparam int unsigned F_OCP_TRIP   = 3;
  localparam int unsigned F_DISABLE    = 4;
  localparam int unsigned F_VCC_ON     = 5;
  localparam int unsigned F_VCC_UNDERVOLTAGE_LOCKOUT   = 6;
  localparam int unsigned F_VCC_REST   = 7;
  localparam int unsigned F_VCC_DROP   = 8;

  typedef enum logic [2:0] {
    BFLC_OFF   = 3'b000,
    BFLC_BOOT  = 3'b001,
    BFLC_RUN   = 3'b011,
    BFLC_BURST = 3'b010,
    BFLC_OCP   = 3'b110,
    BFLC_DIS   = 3'b111
  } bflc_state_e;

  typedef enum logic [1:0] {
    BFLC_OCP_IDLE = 2'b00,
    BFLC_OCP_WARN = 2'b01,
    BFLC_OCP_SHUT = 2'b11
  } bflc_ocp_e;
endpackage : bflc_pkg

//--- inc/bflc_flags_if.sv
// Synchronised comparator flags passed between sequencer parts
`timescale 1ns/1ps
interface bflc_flags_if;
  import bflc_pkg::*;
  logic [FLAG_COUNT-1:0] flag;
  modport src (output flag);
  modport dst (input flag);
endinterface : bflc_flags_if

//--- design/bflc_sync.sv
// Three-stage synchroniser bank for comparator flags
`timescale 1ns/1ps
module bflc_sync
  import bflc_pkg::*;
#(
  parameter int unsigned WIDTH = FLAG_COUNT
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] raw_in,
  bflc_flags_if.src             sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] flag_q;

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      flag_q <= '0;
    end else if (ce_in) begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only once stages two and three agree
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          flag_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sync_out.flag = flag_q;
endmodule : bflc_sync

//--- design/bflc_ocp.sv
// Two-strike overcurrent fault logic
`timescale 1ns/1ps
module bflc_ocp
  import bflc_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  input  wire logic active_in,
  input  wire logic cycle_start_in,
  input  wire logic ocp_trip_in,
  input  wire logic undervoltage_lockout_in,
  output logic      warn_out,
  output logic      shut_out
);
  bflc_ocp_e state_q;
  logic      trip_seen_q;
  logic      warn_cycle_q;

  // overcurrent flag recorded
  // A trip on the cycle-start edge counts for the new cycle, but is lost if the warning clears on that same edge
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      trip_seen_q <= 1'b0;
    end else if (ce_in) begin
      if (!active_in) begin
        trip_seen_q <= 1'b0;
      end else if (cycle_start_in) begin
        trip_seen_q <= ocp_trip_in;
      end else if (ocp_trip_in) begin
        trip_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= BFLC_OCP_IDLE;
    end else if (ce_in) begin
      case (state_q)
        BFLC_OCP_IDLE: begin
          if (active_in && ocp_trip_in) begin
            state_q <= BFLC_OCP_WARN;
          end
        end
        BFLC_OCP_WARN: begin
          if (cycle_start_in && warn_cycle_q) begin
            if (trip_seen_q) begin
              state_q <= BFLC_OCP_SHUT;
            end else begin
              state_q <= BFLC_OCP_IDLE;
            end
          end
        end
        BFLC_OCP_SHUT: begin
          if (undervoltage_lockout_in) begin
            state_q <= BFLC_OCP_IDLE;
          end
        end
        default: state_q <= BFLC_OCP_IDLE;
      endcase
    end
  end

  // The warning trip itself is in the first cycle; look at the next one
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      warn_cycle_q <= 1'b0;
    end else if (ce_in) begin
      if (state_q != BFLC_OCP_WARN) begin
        warn_cycle_q <= 1'b0;
      end else if (cycle_start_in) begin
        warn_cycle_q <= 1'b1;
      end
    end
  end

  assign warn_out = (state_q == BFLC_OCP_WARN);
  assign shut_out = (state_q == BFLC_OCP_SHUT);
endmodule : bflc_ocp

//--- test/bflc_pfc_model.sv
// Behavioural PFC pre-regulator seen through the open-collector stop pin
`timescale 1ns/1ps
module bflc_pfc_model
  import bflc_pkg::*;
(
  input  wire logic stop_oe_in,
  input  wire logic stop_level_in,
  output logic      pin_out,
  output logic      pfc_run_out
);
  assign pin_out     = stop_oe_in ? stop_level_in : 1'b1;
  assign pfc_run_out = pin_out;
endmodule : bflc_pfc_model

//--- test/bflc_chk.sv
// Property checker for the burst and fault latch sequencer
`timescale 1ns/1ps
module bflc_chk
  import bflc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic osc_clock_pulse_in,
  input wire logic sense_at_setpoint_in,
  input wire logic vcc_below_undervoltage_lockout_in,
  input wire logic high_gate_out,
  input wire logic low_gate_out,
  input wire logic osc_enable_out,
  input wire logic low_power_out,
  input wire logic preregulator_stop_oe_out,
  input wire logic hv_start_enable,
  input wire logic ocp_latched_out,
  input wire logic disable_latched_out,
  input wire logic burst_idle_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Cycles since lockout raw flag was high; sync lag makes short gaps unsafe
  logic [2:0] uv_lo_q;
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) uv_lo_q <= 3'h0;
    else if (vcc_below_undervoltage_lockout_in) uv_lo_q <= 3'h0;
    else if (uv_lo_q != 3'h7) uv_lo_q <= uv_lo_q + 3'h1;
  end
  AST_BURST_GATES: assert property (
    $past(ce_in) && burst_idle_out && $past(burst_idle_out) |-> !high_gate_out && !low_gate_out)
    else $error("gates on in burst idle");
  AST_BURST_OSC: assert property (
    burst_idle_out |-> !osc_enable_out && low_power_out) else $error("oscillator on in burst");
  AST_STOP_OE: assert property (
    $past(ce_in) && !$past(burst_idle_out) |-> !preregulator_stop_oe_out)
    else $error("stop pin pulled outside burst idle");
  AST_STOP_HOLD: assert property (
    $past(ce_in) && $past(burst_idle_out) && burst_idle_out |-> preregulator_stop_oe_out)
    else $error("stop pin released in burst idle");
  AST_HIGH_OFF: assert property (
    high_gate_out && $rose(sense_at_setpoint_in) |-> ##[1:7] !high_gate_out)
    else $error("high gate not cut at setpoint");
  AST_PWM_LATCH: assert property (
    $fell(high_gate_out) && !osc_clock_pulse_in ##1 (!osc_clock_pulse_in)[*6] |-> !high_gate_out)
    else $error("second pulse within one cycle");
  AST_OCP_HOLD: assert property (
    ocp_latched_out && uv_lo_q == 3'h7 |=> ocp_latched_out) else $error("overcurrent latch lost");
  AST_OCP_OFF: assert property (
    $past(ce_in) && ocp_latched_out && $past(ocp_latched_out)
    |-> !high_gate_out && !low_gate_out && !hv_start_enable) else $error("active in ocp latch");
  AST_DIS_HOLD: assert property (
    disable_latched_out && uv_lo_q == 3'h7 |=> disable_latched_out)
    else $error("disable latch lost");
  AST_DIS_OFF: assert property (
    $past(ce_in) && disable_latched_out && $past(disable_latched_out)
    |-> !high_gate_out && !low_gate_out && low_power_out) else $error("active in disable latch");
  C_BURST: cover property (burst_idle_out);
  C_OCP: cover property (ocp_latched_out);
  C_DIS: cover property (disable_latched_out);
endmodule : bflc_chk
bind bflc_top bflc_chk u_chk (.mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce_in),
  .osc_clock_pulse_in(osc_clock_pulse_in), .sense_at_setpoint_in(sense_at_setpoint_in),
  .vcc_below_undervoltage_lockout_in(vcc_below_undervoltage_lockout_in), .high_gate_out(high_gate_out),
  .low_gate_out(low_gate_out), .osc_enable_out(osc_enable_out), .low_power_out(low_power_out),
  .preregulator_stop_oe_out(preregulator_stop_oe_out), .hv_start_enable(hv_start_enable),
  .ocp_latched_out(ocp_latched_out), .disable_latched_out(disable_latched_out),
  .burst_idle_out(burst_idle_out));

//--- test/tb_top.sv
// Self-checking bench of the burst and fault latch sequencer
`timescale 1ns/1ps
module tb_top;
  import bflc_pkg::*;
  typedef struct packed {logic stp; logic rsm; logic uv; logic bi; logic oe;} bflc_row_s;
  bflc_row_s rows [6] = '{5'h13, 5'h03, 5'h08, 5'h00, 5'h13, 5'h04};
  logic clk = 1'b0, rst = 1'b1, osc = 1'b0, stp = 1'b0, rsm = 1'b0, sp = 1'b0, oc = 1'b0;
  logic dis = 1'b0, von = 1'b0, uv = 1'b1, vrs = 1'b1, v1 = 1'b0, ce = 1'b1;
  logic hg, lg, oe_en, lp, ps, ps_oe, hv, sg, ow, ol, dl, bi, pin, pfc;
  int   n_errors = 0, num_checks = 0;
  bflc_top dut (.mclk_in(clk), .reset_in(rst), .ce_in(ce), .osc_clock_pulse_in(osc),
    .comp_below_stop_in(stp), .comp_above_restart_in(rsm), .sense_at_setpoint_in(sp),
    .sense_over_ocp_in(oc), .latched_disable_input(dis), .vcc_above_startup_in(von),
    .vcc_below_undervoltage_lockout_in(uv), .vcc_below_restart_in(vrs), .vcc_below_startup_less_1v_in(v1),
    .line_ok_in(1'b1), .high_gate_out(hg), .low_gate_out(lg), .osc_enable_out(oe_en),
    .low_power_out(lp), .preregulator_stop_output(ps), .preregulator_stop_oe_out(ps_oe),
    .hv_start_enable(hv), .supply_good_out(sg), .ocp_warning_out(ow), .ocp_latched_out(ol),
    .disable_latched_out(dl), .burst_idle_out(bi));
  bflc_pfc_model pfc_m (.stop_oe_in(ps_oe), .stop_level_in(ps), .pin_out(pin),
    .pfc_run_out(pfc));
  always #4 clk = ~clk;
  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Oscillator stands still while the block has it stopped
  task automatic pulse(input int n);
    repeat (n) begin
      if (oe_en === 1'b1) osc = 1'b1;
      cyc(1);
      osc = 1'b0;
      cyc(11);
    end
  endtask : pulse
  task automatic pwr;
    uv = 1'b0;
    vrs = 1'b0;
    von = 1'b1;
    cyc(8);
    pulse(14);
  endtask : pwr
  task automatic period(input logic trip);
    oc = trip;
    cyc(8);
    oc = 1'b0;
    pulse(2);
  endtask : period
  initial begin
    #400000;
    n_errors++;
    end_sim;
  end
  initial begin
    cyc(5);
    chk(hg | lg, 1'b0); // gates idle in reset
    chk(ps_oe, 1'b0); // pin released
    chk(hv, 1'b1); // start-up on
    chk(sg, 1'b0); // supply not good
    chk(lp, 1'b1); // low power
    rst = 1'b0;
    pwr;
    chk(sg, 1'b1); // good after start
    chk(oe_en, 1'b1); // running
    foreach (rows[i]) begin
      stp = rows[i].stp;
      rsm = rows[i].rsm;
      uv = rows[i].uv;
      pulse(12);
      chk(bi, rows[i].bi); // burst state
      chk(ps_oe, rows[i].oe); // stop pin
      chk(pfc, ~rows[i].oe); // partner sees pin
      chk(oe_en, ~(rows[i].bi | rows[i].uv)); // oscillator
      if (rows[i].bi) chk(hg | lg, 1'b0); // gates off
    end
    pwr;
    repeat (3) if (hg !== 1'b1) pulse(1);
    chk(hg, 1'b1); // on after cycle start
    sp = 1'b1;
    cyc(8);
    chk(hg, 1'b0); // cut at setpoint
    chk(lg, 1'b1); // low side takes over
    sp = 1'b0;
    cyc(6);
    sp = 1'b1;
    cyc(2);
    sp = 1'b0;
    cyc(8);
    chk(hg, 1'b0); // noise gives no second pulse
    period(1'b1);
    chk(ow, 1'b1); // warning
    chk(ol, 1'b0); // not yet shut
    period(1'b0);
    chk(ow, 1'b0); // clean cycle clears
    chk(ol, 1'b0); // idle again
    period(1'b1);
    period(1'b1);
    chk(ol, 1'b1); // second strike latches
    chk(hg | lg, 1'b0); // stopped
    cyc(20);
    chk(ol, 1'b1); // stays latched
    uv = 1'b1;
    von = 1'b0;
    cyc(12);
    chk(ol, 1'b0); // cleared by lockout
    chk(hv, 1'b0); // start-up still off
    vrs = 1'b1;
    cyc(12);
    chk(hv, 1'b1); // restart allowed
    chk(sg, 1'b0); // supply good dropped
    pwr;
    ce = 1'b0;
    dis = 1'b1;
    cyc(8);
    chk(dl, 1'b0); // flags frozen while ce low
    chk(hg, 1'b1); // gate held while frozen
    ce = 1'b1;
    cyc(8);
    dis = 1'b0;
    cyc(8);
    chk(dl, 1'b1); // latched off
    chk(hg | lg, 1'b0); // gates off
    chk(lp, 1'b1); // low consumption
    chk(hv, 1'b0); // off at start threshold
    von = 1'b0;
    v1 = 1'b1;
    cyc(12);
    chk(hv, 1'b1); // on below lower band
    v1 = 1'b0;
    von = 1'b1;
    cyc(12);
    chk(hv, 1'b0); // off again
    chk(dl, 1'b1); // still latched
    uv = 1'b1;
    von = 1'b0;
    cyc(12);
    chk(dl, 1'b0); // lockout clears
    end_sim;
  end
endmodule : tb_top
